// ===== core/clk_prescale_defines.svh
// Constants for the clock prescaler and interrupt sense control block.
// Assumes inclusion by bare name from core/.
`ifndef CLK_PRESCALE_DEFINES_SVH
`define CLK_PRESCALE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (AXI4-Lite byte addresses)
// ----------------------------------------------------------------------
`define CTRL_ADDR 4'h0
`define CCR_ADDR 4'h4
`define CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Control register fields and CCR mask bits
// ----------------------------------------------------------------------
`define GRP_B_HI 7
`define GRP_B_LO 6
`define CLK_OUT_BIT 5
`define GRP_A_HI 4
`define GRP_A_LO 3
`define DIV_HI 2
`define DIV_LO 1
`define SLOW_BIT 0
`define I1_BIT 5
`define I0_BIT 3
`define CCR_RESET 8'h28

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== core/clk_prescale_pkg.sv
// Types for the clock prescaler and interrupt sense control block.
// Assumes nothing of its surroundings.
package clk_prescale_pkg;
    // Edge and level sense modes of an external interrupt group
    typedef enum logic [1:0] {
        SENSE_FALL_LOW = 2'h0,
        SENSE_RISE = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_BOTH = 2'h3
    } sense_mode_t;
endpackage

// ===== core/clock_prescale_and_irq_sense.sv
// Base and core clock enables, clock-out pin and external interrupt sensing.
// Assumes one clock, synchronous inputs and an AXI4-Lite master.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "clk_prescale_defines.svh"
`default_nettype none

// Function
// R1 - Multiplier on doubles 2-4 MHz input
// R2 - Multiplier off: base clock is oscillator/2
// R3 - Host avoids multiplier with RC oscillator
// R4 - Bits 7:6 set group B sense
// R5 - Bits 4:3 set group A sense
// R6 - Sense fields written only when masked
// R7 - Sense codes: fall+low, rise, fall, both
// R8 - Bit 5 drives core clock to pin
// R9 - Divider field selects 2, 4, 8, 16; the code gives 8 for field 01 and 4 for field 10
// R10 - Slow bit selects divided core clock
// R11 - Masked only when both mask bits set
// R12 - Clock switches without short phases
module clock_prescale_and_irq_sense (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Option and oscillator
    input wire logic pll_enable_in,
    input wire logic osc_tick_in,
    input wire logic osc_is_rc_in,
    // External interrupt pins
    input wire logic ext_irq_group_a_in,
    input wire logic ext_irq_group_b_in,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clocks, pin and interrupt requests
    output logic base_tick_out,
    output logic core_clk_out,
    output logic core_tick_out,
    output logic port_c_bit2_pin_out,
    output logic port_c_bit2_oe_out,
    output logic irq_group_a_out,
    output logic irq_group_b_out,
    output logic rc_pll_misuse_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Sense decode, shared by both interrupt groups
    function automatic logic sense_hit(input logic [1:0] mode, input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (clk_prescale_pkg::sense_mode_t'(mode))
            clk_prescale_pkg::SENSE_FALL_LOW: sense_hit = fall | ~cur;
            clk_prescale_pkg::SENSE_RISE: sense_hit = rise;
            clk_prescale_pkg::SENSE_FALL: sense_hit = fall;
            default: sense_hit = rise | fall;
        endcase
    endfunction

    // Half period of the core clock in base ticks; code 10 is /4, 01 is /8
    function automatic logic [3:0] half_period(input logic slow, input logic [1:0] div);
        if (!slow) begin
            half_period = 4'h0;
        end else begin
            case (div)
                2'h0: half_period = 4'h1;
                2'h2: half_period = 4'h2;
                2'h1: half_period = 4'h4;
                default: half_period = 4'h8;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ccr_r;
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic masked;
    logic wr_go;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;

    // Mask state, as the two condition code priority bits
    assign masked = ccr_r[`I1_BIT] & ccr_r[`I0_BIT]; // see R11

    // Write address and data may come in either order
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
    assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
    assign wr_lane0 = w_got_r ? w_strb_r[0] : s_axi_wstrb[0];
    assign wr_go = (aw_got_r | (s_axi_awvalid & s_axi_awready)) & (w_got_r | (s_axi_wvalid & s_axi_wready));

    // Capture of write channels
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // Write response, unmapped addresses answer SLVERR
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr == `CTRL_ADDR || wr_addr == `CCR_ADDR) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register; sense fields locked unless interrupts are masked
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctrl_r <= `CTRL_RESET;
        end else if (wr_go && wr_lane0 && wr_addr == `CTRL_ADDR) begin
            ctrl_r[`CLK_OUT_BIT] <= wr_data[`CLK_OUT_BIT];
            ctrl_r[`DIV_HI:`DIV_LO] <= wr_data[`DIV_HI:`DIV_LO];
            ctrl_r[`SLOW_BIT] <= wr_data[`SLOW_BIT];
            if (masked) begin
                ctrl_r[`GRP_B_HI:`GRP_B_LO] <= wr_data[`GRP_B_HI:`GRP_B_LO]; // see R4 see R6
                ctrl_r[`GRP_A_HI:`GRP_A_LO] <= wr_data[`GRP_A_HI:`GRP_A_LO]; // see R5 see R6
            end
        end
    end

    // Mirror of the core's mask bits; only bus writes to the CCR address change it
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ccr_r <= `CCR_RESET;
        end else if (wr_go && wr_lane0 && wr_addr == `CCR_ADDR) begin
            ccr_r <= wr_data[7:0];
        end
    end

    // Read channel, one read in flight
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `CTRL_ADDR: s_axi_rdata <= {24'h0, ctrl_r};
                `CCR_ADDR: s_axi_rdata <= {24'h0, ccr_r};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Base clock
    // ------------------------------------------------------------------
    // Oscillator edges as ticks; the doubler is modelled as ticking on every
    // oscillator tick, the divider on every second one
    logic osc_half_r;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            osc_half_r <= 1'b0;
        end else if (osc_tick_in) begin
            osc_half_r <= ~osc_half_r;
        end
    end
    assign base_tick_out = osc_tick_in & (pll_enable_in | osc_half_r); // see R1 see R2
    assign rc_pll_misuse_out = pll_enable_in & osc_is_rc_in; // see R3

    // ------------------------------------------------------------------
    // Core clock
    // ------------------------------------------------------------------
    // New ratio is taken only at a phase boundary, so no phase is cut short
    logic [3:0] half_r;
    logic [3:0] cnt_r;
    logic phase_r;
    logic boundary;
    assign boundary = base_tick_out && (cnt_r + 4'h1 >= half_r);
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            half_r <= 4'h0;
            cnt_r <= 4'h0;
            phase_r <= 1'b0;
        end else if (boundary) begin
            cnt_r <= 4'h0;
            phase_r <= ~phase_r;
            half_r <= half_period(ctrl_r[`SLOW_BIT], ctrl_r[`DIV_HI:`DIV_LO]); // see R9 see R10 see R12
        end else if (base_tick_out) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // In normal mode every base tick is a core tick (see R10)
    assign core_tick_out = (half_r == 4'h0) ? base_tick_out : (boundary & phase_r);
    assign core_clk_out = phase_r;

    // Clock-out alternate function on the port pin
    assign port_c_bit2_pin_out = phase_r & ctrl_r[`CLK_OUT_BIT]; // see R8
    assign port_c_bit2_oe_out = ctrl_r[`CLK_OUT_BIT]; // see R8

    // ------------------------------------------------------------------
    // External interrupt sense
    // ------------------------------------------------------------------
    logic irq_a_prev_r;
    logic irq_b_prev_r;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_a_prev_r <= 1'b1;
            irq_b_prev_r <= 1'b1;
        end else begin
            irq_a_prev_r <= ext_irq_group_a_in;
            irq_b_prev_r <= ext_irq_group_b_in;
        end
    end
    assign irq_group_a_out = sense_hit(ctrl_r[`GRP_A_HI:`GRP_A_LO], ext_irq_group_a_in, irq_a_prev_r); // see R7
    assign irq_group_b_out = sense_hit(ctrl_r[`GRP_B_HI:`GRP_B_LO], ext_irq_group_b_in, irq_b_prev_r); // see R7

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_lock_a;
        @(posedge ref_clk_in) disable iff (rst_in)
        !$past(masked) |-> ctrl_r[`GRP_A_HI:`GRP_A_LO] == $past(ctrl_r[`GRP_A_HI:`GRP_A_LO]);
    endproperty
    a_lock_a: assert property (p_lock_a) else $error("group A sense changed while unmasked"); // see R6
    property p_lock_b;
        @(posedge ref_clk_in) disable iff (rst_in)
        !$past(masked) |-> ctrl_r[`GRP_B_HI:`GRP_B_LO] == $past(ctrl_r[`GRP_B_HI:`GRP_B_LO]);
    endproperty
    a_lock_b: assert property (p_lock_b) else $error("group B sense changed while unmasked"); // see R6
    property p_mask;
        @(posedge ref_clk_in) masked == (ccr_r[`I1_BIT] && ccr_r[`I0_BIT]);
    endproperty
    a_mask: assert property (p_mask) else $error("mask decode wrong"); // see R11
    property p_pin;
        @(posedge ref_clk_in) disable iff (rst_in)
        ctrl_r[`CLK_OUT_BIT] |-> port_c_bit2_oe_out && port_c_bit2_pin_out == core_clk_out;
    endproperty
    a_pin: assert property (p_pin) else $error("clock not on pin"); // see R8
    property p_nopin;
        @(posedge ref_clk_in) !ctrl_r[`CLK_OUT_BIT] |-> !port_c_bit2_oe_out;
    endproperty
    a_nopin: assert property (p_nopin) else $error("pin driven while free"); // see R8
    property p_div2;
        @(posedge ref_clk_in) disable iff (rst_in)
        !pll_enable_in && osc_tick_in && base_tick_out |=> !(osc_tick_in && base_tick_out);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two broken"); // see R2
    property p_pll;
        @(posedge ref_clk_in) disable iff (rst_in)
        pll_enable_in && osc_tick_in |-> base_tick_out;
    endproperty
    a_pll: assert property (p_pll) else $error("doubler missed a tick"); // see R1
    property p_normal;
        @(posedge ref_clk_in) disable iff (rst_in)
        half_r == 4'h0 |-> core_tick_out == base_tick_out;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not base rate"); // see R10
    property p_phase;
        @(posedge ref_clk_in) disable iff (rst_in)
        $changed(phase_r) |-> $past(cnt_r) + 4'h1 >= $past(half_r);
    endproperty
    a_phase: assert property (p_phase) else $error("short core clock phase"); // see R12
    property p_rise;
        @(posedge ref_clk_in) disable iff (rst_in)
        ctrl_r[`GRP_A_HI:`GRP_A_LO] == clk_prescale_pkg::SENSE_RISE && ext_irq_group_a_in && !irq_a_prev_r
            |-> irq_group_a_out;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // see R5
    // Reset leaves interrupts masked, so software may set the sense fields first
    property p_mask_reset;
        @(posedge ref_clk_in) disable iff (rst_in)
        $past(rst_in) |-> masked && ctrl_r == `CTRL_RESET;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("not masked after reset"); // see R11

endmodule
`default_nettype wire

// ===== sim/osc_partner.sv
// Oscillator model: one reference-clock pulse per oscillator cycle.
// Assumes the bench's reference clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module osc_partner (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Oscillator period in reference cycles, 1 or more
    input wire logic [3:0] period_in,
    // Oscillator tick
    output logic osc_tick_out
);
    logic [3:0] cnt_r;
    // ----
    // Period counter; a period of 1 ticks every cycle
    // ----
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || cnt_r >= period_in - 4'h1) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    assign osc_tick_out = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// ===== sim/clock_prescale_and_irq_sense_test.sv
// Self-checking bench for the clock prescaler and sense control block.
// Assumes the oscillator model and an AXI4-Lite master built here.
`timescale 1ns/1ps
`include "clk_prescale_defines.svh"
`default_nettype none
module clock_prescale_and_irq_sense_test;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, pll_enable_in = 1'b0, osc_is_rc_in = 1'b0;
    logic ext_irq_group_a_in = 1'b1, ext_irq_group_b_in = 1'b1, osc_tick_in;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, period = 4'h4;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic base_tick_out, core_clk_out, core_tick_out, port_c_bit2_pin_out, port_c_bit2_oe_out;
    logic irq_group_a_out, irq_group_b_out, rc_pll_misuse_out;
    logic [7:0] ctrl_m = 8'h00, ccr_m = 8'h28;
    int errors = 0, total_checks = 0, c, i, m, g;
    int half_tab[4] = '{1, 4, 2, 8};
    always #12.5 ref_clk_in = ~ref_clk_in;
    clock_prescale_and_irq_sense i_dut (.ref_clk_in, .rst_in, .pll_enable_in, .osc_tick_in,
        .osc_is_rc_in, .ext_irq_group_a_in, .ext_irq_group_b_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base_tick_out, .core_clk_out, .core_tick_out,
        .port_c_bit2_pin_out, .port_c_bit2_oe_out, .irq_group_a_out, .irq_group_b_out,
        .rc_pll_misuse_out);
    osc_partner i_osc (.ref_clk_in, .rst_in, .period_in(period), .osc_tick_out(osc_tick_in));
    // ----
    // Reporting
    // ----
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        check(32'h0, 32'h1);
        final_report();
    endtask
    // ----
    // Bus master; ready is looked at mid-cycle, where it equals its value at the next edge
    // ----
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw, w, b;
        int n;
        @(posedge ref_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk_in);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk_in);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) timeout();
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h, v;
        int n;
        @(posedge ref_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk_in);
            h = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk_in);
            if (h) s_axi_arvalid <= 1'b0;
            if (v) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) timeout();
    endtask
    // Model update, write, read back; sense bits keep their value unless both masks are set
    task automatic set_ctrl(input logic [7:0] d);
        ctrl_m = (ccr_m & 8'h28) == 8'h28 ? d : (d & 8'h27) | (ctrl_m & 8'hD8);
        axi_wr(`CTRL_ADDR, d, rr);
        check(rr, `RESP_OKAY);
        axi_rd(`CTRL_ADDR, rd, rr);
        check(rd, {24'h0, ctrl_m});
    endtask
    // Count base or core ticks over 64 cycles
    task automatic count_base(input logic core, output int n);
        n = 0;
        repeat (64) @(negedge ref_clk_in) n += core ? core_tick_out : base_tick_out;
    endtask
    // Ticks in one core half period, after two phases to settle
    task automatic half_len(output int got);
        int n, t, len;
        logic last;
        t = 0;
        len = 0;
        got = 0;
        last = core_clk_out;
        for (n = 0; n < 300 && t < 3; n++) begin
            @(negedge ref_clk_in);
            if (port_c_bit2_pin_out !== core_clk_out) check(port_c_bit2_pin_out, core_clk_out);
            if (core_clk_out !== last) begin
                t++;
                got = len;
                len = 0;
            end
            len += base_tick_out;
            last = core_clk_out;
        end
        if (t < 3) timeout();
    endtask
    // Move one group's pin, classify the request: 0 none, 1 pulse, 2 level
    task automatic pin_window(input int grp, input logic v, output int cls);
        int n;
        @(posedge ref_clk_in);
        if (grp == 1) ext_irq_group_b_in <= v;
        else ext_irq_group_a_in <= v;
        n = 0;
        repeat (6) @(negedge ref_clk_in) n += (grp == 1) ? irq_group_b_out : irq_group_a_out;
        cls = n == 0 ? 0 : (n >= 4 ? 2 : 1);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(34));
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        axi_rd(`CTRL_ADDR, rd, rr);
        check(rd, 32'h0);
        axi_rd(`CCR_ADDR, rd, rr);
        check(rd, 32'h28);
        axi_rd(4'hC, rd, rr);
        check(rr, `RESP_SLVERR);
        axi_wr(4'h8, 8'hFF, rr);
        check(rr, `RESP_SLVERR);
        for (i = 0; i < 10; i++) begin
            ccr_m = {2'h0, 1'($urandom_range(1)), 1'b0, 1'($urandom_range(1)), 3'h0};
            axi_wr(`CCR_ADDR, ccr_m, rr);
            set_ctrl(8'($urandom_range(255)));
            check(port_c_bit2_oe_out, ctrl_m[5]);
        end
        $display("test register lock done");
        for (i = 0; i < 2; i++) begin
            pll_enable_in <= i[0];
            repeat (8) @(posedge ref_clk_in);
            count_base(1'b0, c);
            check(c, i ? 16 : 8);
        end
        osc_is_rc_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        check(rc_pll_misuse_out, 1'b1);
        osc_is_rc_in <= 1'b0;
        $display("test base clock done");
        period <= 4'h1;
        ccr_m = 8'h28;
        axi_wr(`CCR_ADDR, ccr_m, rr);
        for (m = 0; m < 4; m++) begin
            set_ctrl({2'h0, 1'b1, 2'h0, m[1:0], 1'b1});
            half_len(c);
            check(c, half_tab[m]);
            // One core tick per two half periods, base ticking every cycle
            count_base(1'b1, c);
            check(c, 32 / half_tab[m]);
        end
        set_ctrl(8'h00);
        // The new ratio waits for the running slow phase to end
        repeat (20) @(posedge ref_clk_in);
        repeat (16) @(negedge ref_clk_in) check(core_tick_out, base_tick_out);
        $display("test core clock done");
        for (g = 0; g < 2; g++) begin
            for (m = 0; m < 4; m++) begin
                set_ctrl(g ? {m[1:0], 6'h0} : {3'h0, m[1:0], 3'h0});
                pin_window(g, 1'b0, c);
                check(c, m == 1 ? 0 : (m == 0 ? 2 : 1));
                pin_window(g, 1'b1, c);
                if (m != 0) check(c, (m == 1 || m == 3) ? 1 : 0);
            end
        end
        $display("test sense modes done");
        // Lane 0 strobe low must leave the register alone
        @(posedge ref_clk_in);
        s_axi_wstrb <= 4'hE;
        axi_wr(`CTRL_ADDR, 8'hFF, rr);
        check(rr, `RESP_OKAY);
        axi_rd(`CTRL_ADDR, rd, rr);
        check(rd, {24'h0, ctrl_m});
        s_axi_wstrb <= 4'hF;
        $display("test byte strobe done");
        final_report();
    end
endmodule
`default_nettype wire
